// ---- core/dats_map.svh ----
// Purpose: constants for the handshake and row strobe timing selector
// Assumes: 20 MHz clock, classic wishbone slave with 32-bit data
// Notes:   delays are in half clock periods and whole clock edges
// How it works
// - style bit picks wait or acknowledge handshake
// - burst 00, wait style: wait stays inactive
// - burst 00, ack style: ack stays asserted
// - burst 01 wait: strobe gap waits, release next edge
// - burst 01 ack: strobe gap drops ack, next edge
// - burst 10: gap changes output, half-cycle return
// - burst 11 wait: wait follows strobes, no delay
// - burst 11 ack: ack follows strobes, no delay
// - access 00 wait: only delayed accesses wait
// - access 00 ack: ack with access row strobe
// - access 01: half-cycle wait, one-edge ack
// - access 10: delayed wait half-cycle, ack half-cycle
// - access 11 wait: release one edge after strobe
// - access 11 ack: one and half cycle delay
// - row 00: refresh low 2, precharge 1
// - row 01: refresh low 3, precharge 2
// - row 10: refresh low 2, precharge 2
// - row 11: refresh low 4, precharge 3
// - row 00/10: port strobe first edge after grant
// - row 01/11: port strobe second edge after grant
`ifndef DATS_MAP_SVH
`define DATS_MAP_SVH

// register byte offsets
`define DATS_MODE_OFS      4'h0
`define DATS_STAT_OFS      4'h4
// mode register field positions
`define DATS_ROW_LSB       0
`define DATS_ACC_LSB       2
`define DATS_BST_LSB       4
`define DATS_STYLE_BIT     7
`define DATS_MODE_RST      8'h00
// clock figures
`define DATS_CLK_PERIOD_NS 50
`define DATS_HALF_NS       25
// delays in half clock periods
`define DATS_D0T_HALF      3'd0
`define DATS_DHALF_HALF    3'd1
`define DATS_D1T_HALF      3'd2
`define DATS_D1HT_HALF     3'd3
// refresh low, precharge and grant delay in clock edges
`define DATS_LOW_00        3'd2
`define DATS_LOW_01        3'd3
`define DATS_LOW_10        3'd2
`define DATS_LOW_11        3'd4
`define DATS_PRE_00        3'd1
`define DATS_PRE_01        3'd2
`define DATS_PRE_10        3'd2
`define DATS_PRE_11        3'd3
`define DATS_GNT_FIRST     3'd1
`define DATS_GNT_SECOND    3'd2

`endif

// ---- core/dats_pkg.sv ----
// Purpose: types shared by the timing selector
// Assumes: no header is included; the one-hot state codes are written out here
// Notes:   refresh sequencer is one-hot
package dats_pkg;
  typedef enum logic [2:0] {
    DATS_REF_IDLE = 3'b001,
    DATS_REF_LOW  = 3'b010,
    DATS_REF_PRE  = 3'b100
  } dats_ref_t;

  typedef logic [1:0] dats_sel_t;
endpackage

// ---- core/dats_top.sv ----
// Purpose: handshake and row strobe timing selection for a dram controller
// Assumes: pin inputs other than the asynchronous active-low arst_n_i are synchronous to clk_i, active high asserted levels
// Notes:   half-cycle delays round up to the next rising edge
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "dats_map.svh"

module dats_top (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              access_hold_req_i,
  input  wire logic              access_ras_i,
  input  wire logic              delayed_access_i,
  input  wire logic              ext_col_strobe_in_i,
  input  wire logic              refresh_req_i,
  input  wire logic              second_port_grant_i,
  output logic                   wait_o,
  output logic                   xfer_ack_out_o,
  output logic                   refresh_ras_o,
  output logic                   precharge_busy_o,
  output logic                   port_ras_start_o
);
  import dats_pkg::*;

  // whole edges for a delay given in half periods; a least time rounds up
  function automatic logic [2:0] half_to_edges(input logic [2:0] h);
    half_to_edges = 3'((4'(h) + 4'd1) >> 1);
  endfunction

  // access delay in edges after the access row strobe
  function automatic logic [2:0] acc_dly(input dats_sel_t f, input logic ack);
    case (f)
      2'b00: acc_dly = half_to_edges(`DATS_D0T_HALF);
      2'b01: acc_dly = ack ? half_to_edges(`DATS_D1T_HALF) : half_to_edges(`DATS_DHALF_HALF);
      2'b10: acc_dly = half_to_edges(`DATS_DHALF_HALF);
      default: acc_dly = ack ? half_to_edges(`DATS_D1HT_HALF) : half_to_edges(`DATS_D1T_HALF);
    endcase
  endfunction

  // burst return delay in edges after the strobes reassert
  function automatic logic [2:0] bst_dly(input dats_sel_t f);
    case (f)
      2'b01:   bst_dly = half_to_edges(`DATS_D1T_HALF);
      2'b10:   bst_dly = half_to_edges(`DATS_DHALF_HALF);
      default: bst_dly = half_to_edges(`DATS_D0T_HALF);
    endcase
  endfunction

  function automatic logic [2:0] ref_low(input dats_sel_t f);
    case (f)
      2'b00:   ref_low = `DATS_LOW_00;
      2'b01:   ref_low = `DATS_LOW_01;
      2'b10:   ref_low = `DATS_LOW_10;
      default: ref_low = `DATS_LOW_11;
    endcase
  endfunction

  function automatic logic [2:0] pre_len(input dats_sel_t f);
    case (f)
      2'b00:   pre_len = `DATS_PRE_00;
      2'b01:   pre_len = `DATS_PRE_01;
      2'b10:   pre_len = `DATS_PRE_10;
      default: pre_len = `DATS_PRE_11;
    endcase
  endfunction

  typedef struct packed {
    logic [7:0]  mode;
    logic        ack;
    logic [31:0] rdat;
    logic        ras_q;
    logic [2:0]  acnt;
    logic        ready;
    logic        gap;
    logic [2:0]  bcnt;
    dats_ref_t   rst;
    logic [2:0]  rcnt;
    logic [2:0]  pcnt;
    logic        gnt_q;
    logic [2:0]  gcnt;
    logic        pstart;
    logic        wait_out;
    logic        ack_out;
  } dats_state_t;

  dats_state_t st_r;
  dats_state_t st_nxt;

  dats_sel_t row_f;
  dats_sel_t acc_f;
  dats_sel_t bst_f;
  logic      style;
  logic      wb_req;
  logic      skip_wait;
  logic [2:0] ad;
  logic [2:0] bd;

  // mode fields decoded from the captured register
  assign row_f = st_r.mode[`DATS_ROW_LSB +: 2];
  assign acc_f = st_r.mode[`DATS_ACC_LSB +: 2];
  assign bst_f = st_r.mode[`DATS_BST_LSB +: 2];
  assign style = st_r.mode[`DATS_STYLE_BIT];
  assign wb_req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign ad = acc_dly(acc_f, style);
  assign bd = bst_dly(bst_f);
  // non-delayed accesses skip the access-delay wait in these access settings; burst gaps still wait
  assign skip_wait = ((acc_f == 2'b00) | (acc_f == 2'b10)) & ~delayed_access_i;

  // next-state logic for bus, handshake, refresh and grant timing
  always_comb begin
    st_nxt = st_r;
    // bus slave: one wait-free ack per request, unmapped reads as zero
    st_nxt.ack = wb_req;
    if (wb_req && !wb_we_i) begin
      if (wb_adr_i == `DATS_MODE_OFS) begin
        st_nxt.rdat = {24'h0, st_r.mode};
      end else if (wb_adr_i == `DATS_STAT_OFS) begin
        st_nxt.rdat = {26'h0, st_r.gap, st_r.ready, st_r.pstart,
                       st_r.rst == DATS_REF_PRE, st_r.rst == DATS_REF_LOW, st_r.wait_out};
      end else begin
        st_nxt.rdat = 32'h0;
      end
    end
    // programming: fields change only on a write, never mid-access otherwise
    if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `DATS_MODE_OFS) begin
      st_nxt.mode = wb_dat_i[7:0];
    end

    // access start: count edges with the access row strobe high
    st_nxt.ras_q = access_ras_i;
    if (!access_hold_req_i) begin
      st_nxt.acnt  = 3'd0;
      st_nxt.ready = 1'b0;
    end else if (access_ras_i) begin
      if (st_r.acnt != 3'd7) begin
        st_nxt.acnt = st_r.acnt + 3'd1;
      end
      if (st_r.acnt >= ad) begin
        st_nxt.ready = 1'b1;
      end
    end

    // burst: strobe gap while the access is held
    if (!access_hold_req_i || !st_r.ready || bst_f == 2'b00) begin
      st_nxt.gap  = 1'b0;
      st_nxt.bcnt = 3'd0;
    end else if (!ext_col_strobe_in_i) begin
      st_nxt.gap  = 1'b1;
      st_nxt.bcnt = 3'd0;
    end else if (st_r.gap) begin
      if (st_r.bcnt >= bd) begin
        st_nxt.gap = 1'b0;
      end else begin
        st_nxt.bcnt = st_r.bcnt + 3'd1;
      end
    end
    // zero-delay burst setting clears on the very edge the strobes return
    if (bst_f == 2'b11 && st_nxt.gap && ext_col_strobe_in_i) begin
      st_nxt.gap = 1'b0;
    end

    // handshake outputs, only the selected style is ever active
    if (style) begin
      st_nxt.ack_out  = access_hold_req_i & st_nxt.ready & ~st_nxt.gap;
      st_nxt.wait_out = 1'b0;
    end else begin
      st_nxt.ack_out  = 1'b0;
      st_nxt.wait_out = access_hold_req_i &
                        (st_nxt.gap | (~st_nxt.ready & ~skip_wait));
    end

    // precharge after an access row strobe ends
    if (st_r.pcnt != 3'd0) begin
      st_nxt.pcnt = st_r.pcnt - 3'd1;
    end
    if (st_r.ras_q && !access_ras_i) begin
      st_nxt.pcnt = pre_len(row_f);
    end

    // refresh row strobe: low time then precharge, set by row timing
    case (st_r.rst)
      DATS_REF_IDLE: begin
        if (refresh_req_i && !access_ras_i && st_r.pcnt == 3'd0) begin
          st_nxt.rst  = DATS_REF_LOW;
          st_nxt.rcnt = ref_low(row_f);
        end
      end
      DATS_REF_LOW: begin
        if (st_r.rcnt == 3'd1) begin
          st_nxt.rst  = DATS_REF_PRE;
          st_nxt.rcnt = pre_len(row_f);
        end else begin
          st_nxt.rcnt = st_r.rcnt - 3'd1;
        end
      end
      DATS_REF_PRE: begin
        if (st_r.rcnt == 3'd1) begin
          st_nxt.rst  = DATS_REF_IDLE;
          st_nxt.rcnt = 3'd0;
        end else begin
          st_nxt.rcnt = st_r.rcnt - 3'd1;
        end
      end
      default: begin
        st_nxt.rst  = DATS_REF_IDLE;
        st_nxt.rcnt = 3'd0;
      end
    endcase

    // second-port grant change starts a row strobe one or two edges later
    st_nxt.gnt_q  = second_port_grant_i;
    st_nxt.pstart = 1'b0;
    if (st_r.gcnt != 3'd0) begin
      st_nxt.gcnt = st_r.gcnt - 3'd1;
      if (st_r.gcnt == 3'd1) begin
        st_nxt.pstart = 1'b1;
      end
    end
    if (second_port_grant_i != st_r.gnt_q) begin
      if (row_f[0]) begin
        st_nxt.gcnt = `DATS_GNT_SECOND - 3'd1;
      end else begin
        st_nxt.gcnt   = 3'd0;
        st_nxt.pstart = 1'b1;
      end
    end
  end

  // single state register; reset values are constants only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r      <= '0;
      st_r.mode <= `DATS_MODE_RST;
      st_r.rst  <= DATS_REF_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output straight from the state register
  assign wb_ack_o         = st_r.ack;
  assign wb_dat_o         = st_r.rdat;
  assign wait_o           = st_r.wait_out;
  assign xfer_ack_out_o   = st_r.ack_out;
  assign refresh_ras_o    = (st_r.rst == DATS_REF_LOW);
  assign precharge_busy_o = (st_r.rst == DATS_REF_PRE) | (st_r.pcnt != 3'd0);
  assign port_ras_start_o = st_r.pstart;

  // checks next to the logic they guard
  property p_style_excl;
    @(posedge clk_i) disable iff (!arst_n_i)
      !(wait_o && xfer_ack_out_o);
  endproperty
  a_style_excl: assert property (p_style_excl) else $error("wait and ack both active");

  property p_bst00_ack;
    @(posedge clk_i) disable iff (!arst_n_i)
      (style && bst_f == 2'b00 && xfer_ack_out_o && access_hold_req_i && !wb_req)
        |=> xfer_ack_out_o;
  endproperty
  a_bst00_ack: assert property (p_bst00_ack) else $error("ack dropped in no-wait burst");

  property p_bst00_wait;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!style && bst_f == 2'b00 && st_r.ready && access_hold_req_i && !wb_req)
        |=> !wait_o;
  endproperty
  a_bst00_wait: assert property (p_bst00_wait) else $error("wait in no-wait burst");

  property p_bst01_ret;
    @(posedge clk_i) disable iff (!arst_n_i)
      (bst_f == 2'b01 && st_r.gap && ext_col_strobe_in_i && access_hold_req_i && !wb_req)
        ##1 (ext_col_strobe_in_i && access_hold_req_i && !wb_req)
        |=> !st_r.gap;
  endproperty
  a_bst01_ret: assert property (p_bst01_ret) else $error("burst return late");

  property p_bst11_follow;
    @(posedge clk_i) disable iff (!arst_n_i)
      (bst_f == 2'b11 && style && st_r.ready && access_hold_req_i && !wb_req)
        |=> (xfer_ack_out_o == $past(ext_col_strobe_in_i) || !access_hold_req_i);
  endproperty
  a_bst11_follow: assert property (p_bst11_follow) else $error("ack not following strobes");

  property p_acc00_ack;
    @(posedge clk_i) disable iff (!arst_n_i)
      (style && acc_f == 2'b00 && access_ras_i && access_hold_req_i && !st_r.ras_q
       && ext_col_strobe_in_i && !wb_req) |=> xfer_ack_out_o;
  endproperty
  a_acc00_ack: assert property (p_acc00_ack) else $error("ack late for access setting 00");

  property p_acc11_ack;
    @(posedge clk_i) disable iff (!arst_n_i)
      (style && acc_f == 2'b11 && access_ras_i && !st_r.ras_q && access_hold_req_i && !wb_req)
        |=> !xfer_ack_out_o ##1 !xfer_ack_out_o;
  endproperty
  a_acc11_ack: assert property (p_acc11_ack) else $error("ack early for access setting 11");

  property p_ref_low;
    @(posedge clk_i) disable iff (!arst_n_i)
      ($rose(refresh_ras_o) && row_f == 2'b11 && !wb_req) |-> refresh_ras_o[*4] ##1 !refresh_ras_o;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("refresh low time wrong");

  property p_ref_low00;
    @(posedge clk_i) disable iff (!arst_n_i)
      ($rose(refresh_ras_o) && row_f == 2'b00 && !wb_req) |-> refresh_ras_o[*2] ##1 !refresh_ras_o;
  endproperty
  a_ref_low00: assert property (p_ref_low00) else $error("refresh low time wrong");

  property p_gnt_first;
    @(posedge clk_i) disable iff (!arst_n_i)
      (second_port_grant_i != st_r.gnt_q && !row_f[0]) |=> port_ras_start_o;
  endproperty
  a_gnt_first: assert property (p_gnt_first) else $error("port strobe not on first edge");

  property p_gnt_second;
    @(posedge clk_i) disable iff (!arst_n_i)
      (second_port_grant_i != st_r.gnt_q && row_f[0] && !wb_req)
        |=> !port_ras_start_o ##1 port_ras_start_o;
  endproperty
  a_gnt_second: assert property (p_gnt_second) else $error("port strobe not on second edge");

  property p_mode_hold;
    @(posedge clk_i) disable iff (!arst_n_i)
      !(wb_req && wb_we_i) |=> $stable(st_r.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without a write");

  // half-cycle burst return rounds up to the same edge count as the 01 setting
  property p_bst10_ret;
    @(posedge clk_i) disable iff (!arst_n_i)
      (bst_f == 2'b10 && st_r.gap && ext_col_strobe_in_i && access_hold_req_i && !wb_req)
        ##1 (ext_col_strobe_in_i && access_hold_req_i && !wb_req)
        |=> !st_r.gap;
  endproperty
  a_bst10_ret: assert property (p_bst10_ret) else $error("burst return late");

  // ack one edge after the access row strobe, provided the access is still held
  property p_acc01_ack;
    @(posedge clk_i) disable iff (!arst_n_i)
      (style && acc_f == 2'b01 && access_ras_i && !st_r.ras_q && access_hold_req_i && !wb_req)
        ##1 (access_hold_req_i && access_ras_i && !wb_req)
        |=> xfer_ack_out_o;
  endproperty
  a_acc01_ack: assert property (p_acc01_ack) else $error("ack late for access setting 01");

  // wait style with the longest access delay always inserts a wait state first
  property p_acc11_wait;
    @(posedge clk_i) disable iff (!arst_n_i)
      (!style && acc_f == 2'b11 && access_ras_i && !st_r.ras_q && access_hold_req_i && !wb_req)
        |=> wait_o;
  endproperty
  a_acc11_wait: assert property (p_acc11_wait) else $error("no wait for access setting 11");

  property p_ref_low01;
    @(posedge clk_i) disable iff (!arst_n_i)
      ($rose(refresh_ras_o) && row_f == 2'b01 && !wb_req)
        |-> refresh_ras_o[*3] ##1 !refresh_ras_o;
  endproperty
  a_ref_low01: assert property (p_ref_low01) else $error("refresh low time wrong");

  // refresh precharge length; a refresh starts only with the access strobe low and no access precharge left
  property p_ref_pre11;
    @(posedge clk_i) disable iff (!arst_n_i)
      ($fell(refresh_ras_o) && row_f == 2'b11 && !wb_req)
        |-> precharge_busy_o[*3] ##1 !precharge_busy_o;
  endproperty
  a_ref_pre11: assert property (p_ref_pre11) else $error("refresh precharge wrong");

  // main scenarios worth seeing at least once
  c_refresh: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(refresh_ras_o));
  c_burst:   cover property (@(posedge clk_i) disable iff (!arst_n_i)
                             st_r.gap && xfer_ack_out_o == 1'b0 && style);
  c_wait:    cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(wait_o));
  c_grant:   cover property (@(posedge clk_i) disable iff (!arst_n_i) port_ras_start_o);

endmodule

// ---- sim/dats_cpu_model.sv ----
// Purpose: bus master model that runs one dram access per go pulse
// Assumes: go_i high for one cycle, gap_i counts column strobe gap cycles
// Notes:   idle strobe line toggles so a stale level never looks valid
`timescale 1ns/10ps
module dats_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       dly_i,
  input  wire logic [1:0] gap_i,
  output logic            hold_o,
  output logic            ras_o,
  output logic            dly_o,
  output logic            ext_col_strobe_in_o,
  output logic            done_o
);
  // one access: hold and row strobe together, optional burst gap, release
  initial begin
    {hold_o, ras_o, dly_o, ext_col_strobe_in_o, done_o} = 5'h00;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        hold_o <= 1'b1;
        ras_o  <= 1'b1;
        ext_col_strobe_in_o <= 1'b1;
        dly_o  <= dly_i;
        repeat (5) @(posedge clk_i);
        // gap only after the handshake has settled
        if (gap_i != 2'h0) begin
          ext_col_strobe_in_o <= 1'b0;
          repeat (gap_i) @(posedge clk_i);
          ext_col_strobe_in_o <= 1'b1;
          repeat (4) @(posedge clk_i);
        end
        hold_o <= 1'b0;
        ras_o  <= 1'b0;
        dly_o  <= ~dly_i;
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
      end else begin
        ext_col_strobe_in_o <= ~ext_col_strobe_in_o;
      end
    end
  end
endmodule

// ---- sim/dats_top_tb.sv ----
// Purpose: self-checking bench for the handshake and row timing selector
// Assumes: wishbone answer one cycle after the request edge
// Notes:   half-cycle delays are checked as whole edges, as the design rounds
`timescale 1ns/10ps
module dats_top_tb;
  localparam int DK[4] = '{0, 1, 1, 2};
  localparam int LO[4] = '{2, 3, 2, 4};
  localparam int PR[4] = '{1, 2, 2, 3};
  logic        clk_i, arst_n_i, cyc, stb, we, rq, gnt, go, dly;
  logic        ack, wt, xa, rr, pb, ps, hold, ras, dlo, ext_col_strobe_in, done, gnt_d;
  logic [3:0]  adr, sel;
  logic [1:0]  gap;
  logic [31:0] wdat, rdat, seed;
  logic [31:0] q_rd[$], q_acc[$], q_ref[$], q_gnt[$];
  int          miscompares, num_checks, cycles, ac_cnt, ac_first, ac_hole, wt_cnt;
  int          r_lo, r_pre, g_cnt;

  dats_top u_dats_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .access_hold_req_i(hold), .access_ras_i(ras), .delayed_access_i(dlo),
    .ext_col_strobe_in_i(ext_col_strobe_in), .refresh_req_i(rq), .second_port_grant_i(gnt),
    .wait_o(wt), .xfer_ack_out_o(xa), .refresh_ras_o(rr), .precharge_busy_o(pb),
    .port_ras_start_o(ps));
  dats_cpu_model u_dats_cpu_model (.clk_i(clk_i), .go_i(go), .dly_i(dly), .gap_i(gap),
    .hold_o(hold), .ras_o(ras), .dly_o(dlo), .ext_col_strobe_in_o(ext_col_strobe_in), .done_o(done));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic end_of_test();
    miscompares += q_rd.size() + q_acc.size() + q_ref.size() + q_gnt.size();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr  <= a;
    sel  <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    wb(1'b0, a, 4'hf, rnd());
  endtask

  task automatic acc(input logic d, input logic [1:0] g);
    int n;
    @(posedge clk_i);
    go  <= 1'b1;
    dly <= d;
    gap <= g;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    repeat (6) @(posedge clk_i);
  endtask

  // monitor: measures each result as it appears and checks the oldest note
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      end_of_test();
    end
    if (ack === 1'b1 && we === 1'b0) chk(q_rd.pop_front(), rdat);
    if (hold === 1'b1) begin
      ac_cnt++;
      if (xa === 1'b1 && ac_first == 0) ac_first = ac_cnt;
      else if (xa !== 1'b1 && ac_first != 0) ac_hole++;
      if (wt === 1'b1) wt_cnt++;
    end else if (ac_cnt != 0) begin
      chk(q_acc.pop_front(), ac_first * 16 + ac_hole + wt_cnt);
      {ac_cnt, ac_first, ac_hole, wt_cnt} = '0;
    end
    if (rr === 1'b1) r_lo++;
    if (pb === 1'b1) r_pre++;
    else if (r_pre != 0) begin
      if (r_lo != 0) chk(q_ref.pop_front(), r_lo * 16 + r_pre);
      {r_lo, r_pre} = '0;
    end
    if (ps === 1'b1) begin
      chk(q_gnt.pop_front(), g_cnt);
      g_cnt = 0;
    end
    if (gnt !== gnt_d) g_cnt = 1;
    else if (g_cnt != 0) g_cnt++;
    gnt_d = gnt;
  end

  initial begin
    logic [1:0]  a, g;
    logic        s, d;
    logic [7:0]  md;
    logic [31:0] r;
    {arst_n_i, cyc, stb, we, rq, gnt, go, dly, gnt_d} = '0;
    {adr, sel, gap, wdat} = '0;
    {miscompares, num_checks, cycles, ac_cnt, ac_first, ac_hole, wt_cnt} = '0;
    {r_lo, r_pre, g_cnt} = '0;
    seed = 32'h20;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // reset value, unmapped place, write without the low byte enable
    rd(4'h0, 32'h0);
    wb(1'b1, 4'h8, 4'hf, 32'hff);
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h0);
    wb(1'b1, 4'h0, 4'he, 32'hbf);
    rd(4'h0, 32'h0);
    $display("test registers done");
    // every access and burst delay code in both handshake styles
    for (int i = 0; i < 8; i++) begin
      a = i[2:1];
      s = i[0];
      r = rnd();
      d = r[3];
      g = 2'(1 + r[5:4] % 3);
      md = {s, 1'b0, a, a, 2'b00};
      wb(1'b1, 4'h0, 4'h1, {r[31:8], md});
      rd(4'h0, {24'h0, md});
      q_acc.push_back(s ? (DK[a] + 2) * 16 : ((a == 0 || (a == 2 && !d)) ? 0 : 1));
      q_acc[$] += (a == 0) ? 0 : g + ((a == 3) ? 0 : 1);
      acc(d, g);
    end
    $display("test handshake done");
    // refresh low and precharge counts, grant to row strobe start
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h0, 4'h1, {30'h0, i[1:0]});
      q_ref.push_back(LO[i] * 16 + PR[i]);
      @(posedge clk_i);
      rq <= 1'b1;
      @(posedge clk_i);
      rq <= 1'b0;
      repeat (12) @(posedge clk_i);
      q_gnt.push_back(i[0] ? 2 : 1);
      gnt <= ~gnt;
      repeat (6) @(posedge clk_i);
    end
    $display("test row timing done");
    end_of_test();
  end
endmodule
